//--- rtl/acc_alu_pkg.sv
// Shared constants, operation codes and decode helpers for the accumulator datapath.
package acc_alu_pkg;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int          ACC_W     = 32;
    localparam int          OPND_W    = 16;
    localparam int          SHIFT_W   = 4;
    localparam logic [31:0] ACC_RST   = 32'h0000_0000;
    localparam logic        CARRY_RST = 1'b0;

    // ------------------------------------------------------------------
    // Peripheral mapped register window and timing counts
    // ------------------------------------------------------------------
    localparam logic [15:0] PERIPH_LO    = 16'h0020;
    localparam logic [15:0] PERIPH_HI    = 16'h004F;
    localparam logic [1:0]  CYC_SHORT    = 2'h1;
    localparam logic [1:0]  CYC_LONG     = 2'h2;
    localparam logic [1:0]  CYC_PERIPH   = 2'h1;
    localparam logic [1:0]  WORDS_SHORT  = 2'h1;
    localparam logic [1:0]  WORDS_LONG   = 2'h2;
    localparam logic [31:0] ACC_MOST_NEG = 32'h8000_0000;

    // ------------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_ADD         = 4'h0,
        OP_ADD_CARRY   = 4'h1,
        OP_ADD_BUF_C   = 4'h2,
        OP_ADD_UNS_LO  = 4'h3,
        OP_ADD_VAR_SH  = 4'h4,
        OP_AND         = 4'h5,
        OP_OR          = 4'h6,
        OP_LOAD_SHIFT  = 4'h7,
        OP_LOAD_VAR_SH = 4'h8,
        OP_LOAD_MAPPED = 4'h9,
        OP_LOAD_LOW    = 4'hA,
        OP_ABS         = 4'hB,
        OP_NORMALISE_OP        = 4'hC,
        OP_ROL_PAIR    = 4'hD,
        OP_ROR_PAIR    = 4'hE
    } alu_op_e;

    // True when an access address falls in the peripheral register window.
    function automatic logic is_peripheral(input logic [15:0] addr);
        return (addr >= PERIPH_LO) && (addr <= PERIPH_HI);
    endfunction : is_peripheral

    // True for the operations that accept a long immediate second word.
    function automatic logic takes_long(input alu_op_e op);
        return (op == OP_ADD) || (op == OP_AND) || (op == OP_OR) || (op == OP_LOAD_SHIFT);
    endfunction : takes_long

endpackage : acc_alu_pkg

//--- rtl/alu_link_if.sv
// Operand and result bundle between the sequencer and the arithmetic core.
interface alu_link_if;
    acc_alu_pkg::alu_op_e op;
    logic [31:0]          acc;
    logic [31:0]          abuf;
    logic                 carry;
    logic                 sxm;
    logic [15:0]          operand;
    logic [3:0]           shift;
    logic [31:0]          res_acc;
    logic [31:0]          res_abuf;
    logic                 res_carry;

    modport core (input op, acc, abuf, carry, sxm, operand, shift,
                  output res_acc, res_abuf, res_carry);
    modport user (output op, acc, abuf, carry, sxm, operand, shift,
                  input res_acc, res_abuf, res_carry);
endinterface : alu_link_if

//--- rtl/alu_core.sv
// Combinational arithmetic, logic, shift and rotate core.
module alu_core (
    alu_link_if.core lk     // Operands in, results out.
);
    logic [31:0] ext;
    logic [31:0] shifted;
    logic [32:0] sum;

    // Operand extension and left shift ahead of the adder.
    always_comb begin
        ext     = lk.sxm ? {{16{lk.operand[15]}}, lk.operand} : {16'h0000, lk.operand};
        shifted = ext << lk.shift;
    end

    // Result selection; carry only moves on the adds and the pair rotates.
    always_comb begin
        sum          = 33'h0_0000_0000;
        lk.res_acc   = lk.acc;
        lk.res_abuf  = lk.abuf;
        lk.res_carry = lk.carry;
        case (lk.op)
            acc_alu_pkg::OP_ADD, acc_alu_pkg::OP_ADD_VAR_SH: begin
                sum          = {1'b0, lk.acc} + {1'b0, shifted};
                lk.res_acc   = sum[31:0];
                lk.res_carry = sum[32];
            end
            acc_alu_pkg::OP_ADD_CARRY: begin
                sum          = {1'b0, lk.acc} + {1'b0, ext} + {32'h0000_0000, lk.carry};
                lk.res_acc   = sum[31:0];
                lk.res_carry = sum[32];
            end
            acc_alu_pkg::OP_ADD_BUF_C: begin
                sum          = {1'b0, lk.acc} + {1'b0, lk.abuf} + {32'h0000_0000, lk.carry};
                lk.res_acc   = sum[31:0];
                lk.res_carry = sum[32];
            end
            acc_alu_pkg::OP_ADD_UNS_LO: begin
                // Sign mode is ignored here on purpose.
                sum          = {1'b0, lk.acc} + {17'h0_0000, lk.operand};
                lk.res_acc   = sum[31:0];
                lk.res_carry = sum[32];
            end
            acc_alu_pkg::OP_AND: lk.res_acc = lk.acc & shifted;
            acc_alu_pkg::OP_OR: lk.res_acc = lk.acc | shifted;
            acc_alu_pkg::OP_LOAD_SHIFT, acc_alu_pkg::OP_LOAD_VAR_SH: lk.res_acc = shifted;
            acc_alu_pkg::OP_LOAD_MAPPED, acc_alu_pkg::OP_LOAD_LOW: begin
                lk.res_acc = {16'h0000, lk.operand};
            end
            acc_alu_pkg::OP_ABS: begin
                // The most negative value has no positive twin and stays put.
                lk.res_acc = lk.acc[31] ? 32'(-lk.acc) : lk.acc;
            end
            acc_alu_pkg::OP_NORMALISE_OP: begin
                if ((lk.acc[31] == lk.acc[30]) && (lk.acc != 32'h0000_0000)) begin
                    lk.res_acc = {lk.acc[30:0], 1'b0};
                end
            end
            acc_alu_pkg::OP_ROL_PAIR: begin
                {lk.res_carry, lk.res_abuf, lk.res_acc} = {lk.abuf, lk.acc, lk.carry};
            end
            acc_alu_pkg::OP_ROR_PAIR: begin
                {lk.res_abuf, lk.res_acc, lk.res_carry} = {lk.carry, lk.abuf, lk.acc};
            end
            default: lk.res_acc = lk.acc;
        endcase
    end
endmodule : alu_core

//--- rtl/cycle_timer.sv
// Down counter that marks the last stall cycle of a multi-cycle operation.
module cycle_timer (
    input  wire logic       ref_clk,   // Core clock.
    input  wire logic       rst_b,     // Asynchronous reset, active low.
    input  wire logic       load,      // Start a count.
    input  wire logic [1:0] count_in,  // Cycles to wait.
    output logic            last       // High in the final waited cycle.
);
    typedef struct packed {
        logic [1:0] remain;
    } timer_s;

    timer_s s_q;
    timer_s s_d;

    // Reload on start, otherwise count down to zero.
    always_comb begin
        s_d = s_q;
        if (load) begin
            s_d.remain = count_in;
        end else if (s_q.remain != 2'h0) begin
            s_d.remain = s_q.remain - 2'h1;
        end
    end

    // State register.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign last = (s_q.remain == 2'h1);
endmodule : cycle_timer

//--- rtl/accumulator_alu_datapath.sv
// Accumulator datapath: operation sequencer, timing and state registers.
// Function
// - Add/AND/OR/load-shift: long immediate costs two cycles.
// - Peripheral mapped register access adds one cycle.
// - Mapped load: one cycle processor, two peripheral.
// - Add buffer plus carry in one cycle.
// - Add memory operand plus carry, one cycle.
// - Unsigned low add ignores sign mode, one cycle.
// - Variable shift taken from shift count register.
// - Absolute value of accumulator in one cycle.
// - One normalisation step drops a sign bit.
// - Pair rotates through carry, both directions.
// - Low-word load clears the high half.
// - Counts assume internal memory, single execution.
module accumulator_alu_datapath (
    input  wire logic                 ref_clk,              // Core clock, 20 MHz.
    input  wire logic                 rst_b,                // Asynchronous reset, active low.
    input  wire logic                 op_valid,             // Decoder presents an operation.
    input  acc_alu_pkg::alu_op_e      op_code,              // Operation to run.
    input  wire logic                 long_imm,             // Second word carries the operand.
    input  wire logic                 mem_access,           // Operand comes over data space.
    input  wire logic [15:0]          mem_addr,             // Data space address of operand.
    input  wire logic [15:0]          operand,              // Operand value.
    input  wire logic [3:0]           shift_code,           // Immediate left shift.
    input  wire logic [3:0]           shift_count_register, // Low bits of shift register.
    input  wire logic                 sign_ext_mode,        // Sign extend operands.
    output logic                      op_ready,             // Ready to take an operation.
    output logic                      op_done,              // Result committed last edge.
    output logic [31:0]               acc_out,              // Accumulator.
    output logic [31:0]               accumulator_buffer,   // Accumulator buffer.
    output logic                      carry_out,            // Carry bit.
    output logic [1:0]                words_used,           // Program words of last op.
    output logic [1:0]                cycles_used           // Cycles of last op.
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } seq_state_e;

    typedef struct packed {
        seq_state_e  st;
        logic [31:0] acc;
        logic [31:0] abuf;
        logic        carry;
        logic [31:0] p_acc;
        logic [31:0] p_abuf;
        logic        p_carry;
        logic        ready;
        logic        done;
        logic [1:0]  words;
        logic [1:0]  cycles;
    } dp_s;

    dp_s s_q;
    dp_s s_d;

    alu_link_if lk ();

    logic       accept;
    logic       periph;
    logic       is_long;
    logic [1:0] n_cyc;
    logic       t_load;
    logic       t_last;

    // ------------------------------------------------------------------
    // Timing decode
    // ------------------------------------------------------------------
    // Cycle count per operation; figures assume internal program RAM and
    // dual-access data memory, with no repeat, so no wait states appear.
    always_comb begin
        accept  = op_valid && s_q.ready;
        periph  = mem_access && acc_alu_pkg::is_peripheral(mem_addr);
        is_long = long_imm && acc_alu_pkg::takes_long(op_code);
        n_cyc   = is_long ? acc_alu_pkg::CYC_LONG : acc_alu_pkg::CYC_SHORT;
        // A peripheral access rides the slower bus, one cycle more.
        if (periph) begin
            n_cyc = n_cyc + acc_alu_pkg::CYC_PERIPH;
        end
        t_load = accept && (n_cyc != acc_alu_pkg::CYC_SHORT);
    end

    // ------------------------------------------------------------------
    // Core hookup
    // ------------------------------------------------------------------
    // Variable shift ops take their amount from the shift count register.
    always_comb begin
        lk.op      = op_code;
        lk.acc     = s_q.acc;
        lk.abuf    = s_q.abuf;
        lk.carry   = s_q.carry;
        lk.sxm     = sign_ext_mode;
        lk.operand = operand;
        lk.shift   = shift_code;
        if ((op_code == acc_alu_pkg::OP_ADD_VAR_SH) ||
            (op_code == acc_alu_pkg::OP_LOAD_VAR_SH)) begin
            lk.shift = shift_count_register;
        end
    end

    alu_core u_core (
        .lk (lk.core)
    );

    cycle_timer u_timer (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .load     (t_load),
        .count_in (2'(n_cyc - 2'h1)),
        .last     (t_last)
    );

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Results are computed at acceptance and held until the last cycle, so
    // the operand bus need not stay stable during the stall.
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        case (s_q.st)
            ST_IDLE: begin
                if (accept) begin
                    s_d.words  = is_long ? acc_alu_pkg::WORDS_LONG
                                         : acc_alu_pkg::WORDS_SHORT;
                    s_d.cycles = n_cyc;
                    if (n_cyc == acc_alu_pkg::CYC_SHORT) begin
                        // Single-cycle ops commit at once.
                        s_d.acc   = lk.res_acc;
                        s_d.abuf  = lk.res_abuf;
                        s_d.carry = lk.res_carry;
                        s_d.done  = 1'b1;
                    end else begin
                        s_d.p_acc   = lk.res_acc;
                        s_d.p_abuf  = lk.res_abuf;
                        s_d.p_carry = lk.res_carry;
                        s_d.ready   = 1'b0;
                        s_d.st      = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (t_last) begin
                    s_d.acc   = s_q.p_acc;
                    s_d.abuf  = s_q.p_abuf;
                    s_d.carry = s_q.p_carry;
                    s_d.done  = 1'b1;
                    s_d.ready = 1'b1;
                    s_d.st    = ST_IDLE;
                end
            end
            default: begin
                s_d.st    = ST_IDLE;
                s_d.ready = 1'b1;
            end
        endcase
    end

    // State register; all outputs come straight from here.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q         <= '0;
            s_q.st      <= ST_IDLE;
            s_q.acc     <= acc_alu_pkg::ACC_RST;
            s_q.abuf    <= acc_alu_pkg::ACC_RST;
            s_q.carry   <= acc_alu_pkg::CARRY_RST;
            s_q.ready   <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign op_ready           = s_q.ready;
    assign op_done            = s_q.done;
    assign acc_out            = s_q.acc;
    assign accumulator_buffer = s_q.abuf;
    assign carry_out          = s_q.carry;
    assign words_used         = s_q.words;
    assign cycles_used        = s_q.cycles;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    logic single;
    assign single = accept && (n_cyc == acc_alu_pkg::CYC_SHORT);

    a_long_two_cyc: assert property (
        accept && is_long && !periph |=> !op_done && !op_ready ##1 op_done && op_ready
    ) else $error("long immediate op did not take two cycles");

    a_periph_extra: assert property (
        accept && periph && !is_long |=> !op_done ##1 op_done && cycles_used == 2'h2
    ) else $error("peripheral access did not add one cycle");

    a_mapped_proc: assert property (
        accept && op_code == acc_alu_pkg::OP_LOAD_MAPPED && !periph |=> op_done
    ) else $error("processor mapped load not single cycle");

    a_buf_carry_add: assert property (
        single && op_code == acc_alu_pkg::OP_ADD_BUF_C |=>
        acc_out == 32'($past(acc_out) + $past(accumulator_buffer) + {31'h0, $past(carry_out)})
    ) else $error("buffer add with carry wrong");

    a_mem_carry_add: assert property (
        single && op_code == acc_alu_pkg::OP_ADD_CARRY && !sign_ext_mode |=>
        acc_out == 32'($past(acc_out) + {16'h0, $past(operand)} + {31'h0, $past(carry_out)})
    ) else $error("memory add with carry wrong");

    a_uns_low_add: assert property (
        single && op_code == acc_alu_pkg::OP_ADD_UNS_LO |=>
        acc_out == 32'($past(acc_out) + {16'h0, $past(operand)})
    ) else $error("unsigned low add sign extended");

    a_var_shift_ld: assert property (
        single && op_code == acc_alu_pkg::OP_LOAD_VAR_SH && !sign_ext_mode |=>
        acc_out == ({16'h0, $past(operand)} << $past(shift_count_register))
    ) else $error("variable shift load wrong");

    a_abs_result: assert property (
        single && op_code == acc_alu_pkg::OP_ABS |=>
        !acc_out[31] || acc_out == acc_alu_pkg::ACC_MOST_NEG
    ) else $error("absolute value negative");

    a_normalise_op_step: assert property (
        single && op_code == acc_alu_pkg::OP_NORMALISE_OP && (acc_out[31] ^ acc_out[30]) |=>
        $stable(acc_out)
    ) else $error("normalised value shifted again");

    a_rol_pair: assert property (
        single && op_code == acc_alu_pkg::OP_ROL_PAIR |=>
        carry_out == $past(accumulator_buffer[31]) && acc_out[0] == $past(carry_out)
    ) else $error("pair rotate left wrong");

    a_low_load: assert property (
        single && op_code == acc_alu_pkg::OP_LOAD_LOW |=>
        acc_out == {16'h0000, $past(operand)}
    ) else $error("low word load did not clear high half");

    c_long_op:   cover property (accept && is_long ##2 op_done);
    c_periph_op: cover property (accept && periph ##1 !op_done ##1 op_done);
    c_rotate:    cover property (single && op_code == acc_alu_pkg::OP_ROR_PAIR);

endmodule : accumulator_alu_datapath

//--- testbench/data_memory_model.sv
// Behavioural data memory that supplies operands over data space.
module data_memory_model (
    input  wire logic        sel,   // Operand read in progress.
    input  wire logic [15:0] addr,  // Data space address.
    output logic      [15:0] rdata  // Read data.
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [15:0] mem [0:255];

    // A fixed scrambled pattern gives every address a distinct word.
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 16'(i * 40503) ^ 16'h5A5A;
        end
    end

    // Internal dual-access memory answers in the same cycle; when not selected
    // the bus shows the inverse word so a stale value can never pass for data.
    always_comb begin
        rdata = sel ? mem[addr[7:0]] : ~mem[addr[7:0]];
    end
endmodule : data_memory_model

//--- testbench/tb.sv
// Self-checking testbench with a reference model of the accumulator datapath.
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Stimulus and observation signals
    // ------------------------------------------------------------------
    logic                 ref_clk, rst_b, op_valid, long_imm, mem_access, sign_ext_mode;
    acc_alu_pkg::alu_op_e op_code;
    logic [15:0]          mem_addr, imm_val, mem_data, operand;
    logic [3:0]           shift_code, shift_count_register;
    logic                 op_ready, op_done, carry_out;
    logic [31:0]          acc_out, accumulator_buffer;
    logic [1:0]           words_used, cycles_used;
    logic [31:0]          m_acc, m_buf;
    logic                 m_c;
    int                   miscompares, comparisons;

    // The operand comes from data memory when an access is made.
    assign operand = mem_access ? mem_data : imm_val;

    data_memory_model MEM (.sel(mem_access), .addr(mem_addr), .rdata(mem_data));

    accumulator_alu_datapath DUT (
        .ref_clk(ref_clk), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
        .long_imm(long_imm), .mem_access(mem_access), .mem_addr(mem_addr),
        .operand(operand), .shift_code(shift_code),
        .shift_count_register(shift_count_register), .sign_ext_mode(sign_ext_mode),
        .op_ready(op_ready), .op_done(op_done), .acc_out(acc_out),
        .accumulator_buffer(accumulator_buffer), .carry_out(carry_out),
        .words_used(words_used), .cycles_used(cycles_used));

    // Free-running core clock at 20 MHz.
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict;
        $display("Compared %0d values, %0d wrong", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    // Issues one operation, steps the model, then waits for completion.
    task automatic do_op(input int op, input logic lng, input logic ma, input logic [15:0] addr,
                         input logic [15:0] imm, input logic [3:0] sc, input logic [3:0] tr,
                         input logic sx);
        logic [31:0] ext, sh;
        logic [32:0] sum;
        int          wd, cyc, n;
        op_code = acc_alu_pkg::alu_op_e'(op);
        long_imm = lng;
        mem_access = ma;
        mem_addr = addr;
        imm_val = imm;
        shift_code = sc;
        shift_count_register = tr;
        sign_ext_mode = sx;
        op_valid = 1'b1;
        check(op_ready, 1);
        #1;
        ext = (sx && !(op inside {3, 9, 10})) ? {{16{operand[15]}}, operand} : {16'h0000, operand};
        sh = (op inside {0, 5, 6, 7}) ? ext << sc : (op inside {4, 8}) ? ext << tr : ext;
        wd = (lng && op inside {0, 5, 6, 7}) ? 2 : 1;
        cyc = wd + int'(ma && addr >= 16'h0020 && addr <= 16'h004F);
        case (op)
            0, 1, 3, 4: sum = {1'b0, m_acc} + {1'b0, sh} + ((op == 1) ? 33'(m_c) : 33'h0);
            2:          sum = {1'b0, m_acc} + {1'b0, m_buf} + 33'(m_c);
            default:    sum = {m_c, m_acc};
        endcase
        case (op)
            5:       m_acc = m_acc & sh;
            6:       m_acc = m_acc | sh;
            7, 8:    m_acc = sh;
            9, 10:   m_acc = ext;
            11:      m_acc = m_acc[31] ? -m_acc : m_acc;
            12:      m_acc = (m_acc[31] == m_acc[30] && m_acc != 0) ? m_acc << 1 : m_acc;
            13:      {m_c, m_buf, m_acc} = {m_buf, m_acc, m_c};
            14:      {m_buf, m_acc, m_c} = {m_c, m_buf, m_acc};
            default: {m_c, m_acc} = sum;
        endcase
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
            if (n == 1 && cyc > 1) begin
                check(op_ready, 0);
                // A fresh request offered during the stall must be ignored.
                op_code = acc_alu_pkg::alu_op_e'((op + 1) % 15);
                imm_val = ~imm_val;
                mem_addr = ~mem_addr;
            end
        end while (op_done !== 1'b1 && n < 6);
        check(n, cyc);
        check(cycles_used, cyc);
        check(words_used, wd);
        check(acc_out, m_acc);
        check(accumulator_buffer, m_buf);
        check(carry_out, m_c);
    endtask : do_op

    task automatic reset_all;
        rst_b = 1'b0;
        op_valid = 1'b0;
        m_acc = 0;
        m_buf = 0;
        m_c = 0;
        repeat (20) @(posedge ref_clk);
        #1;
        check(acc_out, 32'h0000_0000);
        check(accumulator_buffer, 32'h0000_0000);
        check({op_ready, op_done, carry_out, words_used, cycles_used}, 32'h0000_0040);
        rst_b = 1'b1;
    endtask : reset_all

    // Cuts a hang short well beyond the expected run length.
    initial begin
        #(50 * 8000);
        miscompares++;
        print_verdict();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [15:0] bounds [4];
        int          op;
        miscompares = 0;
        comparisons = 0;
        {op_valid, long_imm, mem_access, sign_ext_mode} = 4'h0;
        op_code = acc_alu_pkg::OP_ADD;
        {mem_addr, imm_val, shift_code, shift_count_register} = 40'h0;
        void'($urandom(32'hE490));
        reset_all();
        bounds = '{16'h001F, 16'h0020, 16'h004F, 16'h0050};
        // Every code short and then with a long immediate word, back to back.
        for (int k = 0; k < 30; k++) begin
            do_op(k % 15, k >= 15, 0, 0, 16'h8421 + 16'(k * 16'h1357), 4'(k), 4'(k + 3), k[0]);
        end
        // Mapped loads and plain adds on both sides of the peripheral window.
        for (int k = 0; k < 8; k++) begin
            do_op(k < 4 ? 9 : 0, 0, 1, bounds[k % 4], 0, 4'h1, 0, 1);
        end
        // Build the most negative value, take its magnitude, then reload low.
        do_op(7, 0, 0, 0, 16'h4000, 4'hF, 0, 0);
        repeat (3) do_op(0, 0, 0, 0, 16'h4000, 4'hF, 0, 0);
        do_op(11, 0, 0, 0, 0, 0, 0, 0);
        do_op(10, 0, 0, 0, 16'hF00D, 0, 0, 1);
        do_op(7, 0, 0, 0, 16'h0003, 0, 0, 1);
        repeat (4) do_op(12, 0, 0, 0, 0, 0, 0, 0);
        do_op(7, 0, 0, 0, 16'h8001, 0, 0, 1);
        repeat (6) do_op(13, 0, 0, 0, 0, 0, 0, 0);
        repeat (3) do_op(14, 0, 0, 0, 0, 0, 0, 0);
        do_op(2, 0, 0, 0, 0, 0, 0, 0);
        // Random traffic over all codes, shifts and modes, and addresses from 16'h0000 to 16'h005F.
        for (int k = 0; k < 300; k++) begin
            op = $urandom % 15;
            if (($urandom % 3) == 0) begin
                do_op(op, 0, 1, 16'($urandom % 16'h0060), 0, 4'($urandom), 4'($urandom),
                      1'($urandom));
            end else begin
                do_op(op, 1'($urandom), 0, 0, 16'($urandom), 4'($urandom), 4'($urandom),
                      1'($urandom));
            end
            if (k == 150) begin
                reset_all();
            end
        end
        op_valid = 1'b0;
        @(posedge ref_clk);
        #1;
        check(op_done, 0);
        print_verdict();
    end
endmodule : tb
